// ==== inc/exc_mask_pkg.sv ====
// Shared constants and carrier types for the exception mask and stack control block
package exc_mask_pkg;
	localparam int          DATA_W          = 32;
	localparam int          PRIO_W          = 4;
	localparam int          SEL_W           = 2;
	// Special register selectors on the move-instruction port
	localparam logic [1:0]  SEL_PRI_MASK    = 2'h0;
	localparam logic [1:0]  SEL_FAULT_MASK  = 2'h1;
	localparam logic [1:0]  SEL_THRESHOLD   = 2'h2;
	localparam logic [1:0]  SEL_CONTROL     = 2'h3;
	// Field positions
	localparam int          MASK_BIT        = 0;
	localparam int          THRESH_LSB      = 4;
	localparam int          THRESH_MSB      = 7;
	localparam int          CTRL_UNPRIV_BIT = 0;
	localparam int          CTRL_STACK_BIT  = 1;
	localparam int          CTRL_FLOAT_BIT  = 2;
	// Reset values
	localparam logic        MASK_RESET      = 1'b0;
	localparam logic [3:0]  THRESH_RESET    = 4'h0;
	localparam logic [3:0]  THRESH_OFF      = 4'h0;
	localparam logic        CTRL_BIT_RESET  = 1'b0;
	localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
	// Return code bits: bits 3 and 2 both set mean return to thread onto the process stack
	localparam int          RET_STACK_BIT   = 2;
	localparam int          RET_THREAD_BIT  = 3;
	localparam int          RET_FP_BIT      = 4;

	typedef struct packed {
		logic                 write;
		logic                 read;
		logic [SEL_W-1:0]     sel;
		logic [DATA_W-1:0]    wdata;
	} special_req_t;

	typedef struct packed {
		logic                 valid;
		logic                 set;
		logic                 affect_pri;
		logic                 affect_fault;
	} change_state_t;

	typedef struct packed {
		logic                 take;
		logic                 is_nmi;
		logic                 configurable;
		logic [PRIO_W-1:0]    prio;
	} exc_req_t;

	typedef enum logic [2:0] {
		MODE_RESET   = 3'b001,
		MODE_THREAD  = 3'b010,
		MODE_HANDLER = 3'b100
	} mode_t;
endpackage : exc_mask_pkg

// ==== design/prio_gate.sv ====
// Combinational gate deciding whether a pending exception may be activated
module prio_gate #(
	parameter int PRIO_W = exc_mask_pkg::PRIO_W
) (
	input  wire logic              pri_mask,
	input  wire logic              fault_mask,
	input  wire logic [PRIO_W-1:0] threshold,
	input  wire logic              is_nmi,
	input  wire logic              configurable,
	input  wire logic [PRIO_W-1:0] prio,
	output logic                   allowed
);
	// The off value is four bits wide, so wider fields cannot be served
	if (PRIO_W < 1 || PRIO_W > 4) begin : g_prio_w_check
		$error("prio_gate: PRIO_W out of range");
	end

	// Larger value means lower urgency
	function automatic logic at_or_below(input logic [PRIO_W-1:0] p, input logic [PRIO_W-1:0] t);
		return p >= t;
	endfunction : at_or_below

	always_comb begin
		allowed = 1'b1;
		if (!is_nmi) begin
			if (fault_mask) allowed = 1'b0;
			if (pri_mask && configurable) allowed = 1'b0;
			if (configurable && threshold != exc_mask_pkg::THRESH_OFF[PRIO_W-1:0]
			    && at_or_below(prio, threshold)) allowed = 1'b0;
		end
	end
endmodule : prio_gate

// ==== design/special_read_mux.sv ====
// Read multiplexer that formats the four special registers onto a 32-bit word
module special_read_mux (
	input  wire logic [1:0] sel,
	input  wire logic       pri_mask,
	input  wire logic       fault_mask,
	input  wire logic [3:0] threshold,
	input  wire logic       ctrl_float,
	input  wire logic       ctrl_stack,
	input  wire logic       ctrl_unpriv,
	input  wire logic       in_handler,
	output logic     [31:0] rdata
);
	always_comb begin
		rdata = exc_mask_pkg::ZERO_WORD;
		unique case (sel)
			exc_mask_pkg::SEL_PRI_MASK: begin
				rdata[exc_mask_pkg::MASK_BIT] = pri_mask;
			end
			exc_mask_pkg::SEL_FAULT_MASK: begin
				rdata[exc_mask_pkg::MASK_BIT] = fault_mask;
			end
			exc_mask_pkg::SEL_THRESHOLD: begin
				rdata[exc_mask_pkg::THRESH_MSB:exc_mask_pkg::THRESH_LSB] = threshold;
			end
			exc_mask_pkg::SEL_CONTROL: begin
				rdata[exc_mask_pkg::CTRL_FLOAT_BIT]  = ctrl_float;
				rdata[exc_mask_pkg::CTRL_STACK_BIT]  = ctrl_stack & ~in_handler;
				rdata[exc_mask_pkg::CTRL_UNPRIV_BIT] = ctrl_unpriv;
			end
		endcase
	end
endmodule : special_read_mux

// ==== design/exception_mask_and_stack_control.sv ====
// Exception mask registers, thread control register and mode tracking of the core
//
// Behaviour
// - While the configurable priority mask is set, no configurable-priority exception activates.
// - While the fault level mask is set, only the non-maskable interrupt may activate.
// - Leaving any handler other than the non-maskable one clears the fault level mask.
// - A nonzero threshold blocks every configurable-priority exception whose priority value is at or above it.
// - A threshold of zero disables threshold masking.
// - A numerically larger priority value is treated as lower priority.
// - Control bit 2 shows whether a floating-point context is active and steers state saving.
// - Control bit 1 picks main (0) or process (1) stack pointer in thread mode.
// - Handler mode always uses the main stack; bit 1 reads zero and ignores writes there.
// - Exception entry and return update the control register, return reloading stack select.
// - Control bit 0 makes thread code privileged (0) or unprivileged (1).
// - Thread starts on the main stack and moves to the process stack by write or return code.
// - Masks are read and written by special moves; change-state sets or clears the two masks.
// - Every exception handler runs in handler mode, reset being the only exception outside it.
module exception_mask_and_stack_control #(
	parameter int PRIO_W = exc_mask_pkg::PRIO_W
) (
	input  wire logic                        clock,
	input  wire logic                        nrst,
	input  wire exc_mask_pkg::special_req_t  special_req,
	input  wire exc_mask_pkg::change_state_t change_state,
	input  wire exc_mask_pkg::exc_req_t      exc_req,
	input  wire logic                        handler_exit,
	input  wire logic                        return_from_nmi,
	input  wire logic [7:0]                  return_code,
	input  wire logic                        fp_instr_exec,
	input  wire logic                        thread_privileged_in,
	output logic [31:0]                      read_data,
	output logic                             read_valid,
	output logic                             exc_accept,
	output logic                             exc_save_fp,
	output logic                             in_handler,
	output logic                             use_process_stack,
	output logic                             thread_unprivileged,
	output logic                             pri_mask_out,
	output logic                             fault_mask_out,
	output logic [3:0]                       threshold_out
);
	// Register layout fixes the threshold field at four bits
	if (PRIO_W != 4) begin : g_prio_w_check
		$error("exception_mask_and_stack_control: PRIO_W must be 4");
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// State
	exc_mask_pkg::mode_t mode;
	exc_mask_pkg::mode_t next_mode;
	logic                configurable_priority_mask;
	logic                fault_level_mask;
	logic [3:0]          priority_threshold;
	logic                float_context_active;
	logic                stack_select;
	logic                unpriv_bit;
	logic                allowed;
	logic [31:0]         mux_data;
	logic                handler_now;
	logic                entry;
	logic                wr_ok;
	logic                exit_now;
	logic                pri_mask_hit;
	logic                fault_mask_hit;
	logic                thresh_hit;
	logic                ctrl_hit;

	// Privileged special-register write aimed at one selector
	function automatic logic write_hits(
		input logic                           ok,
		input logic [exc_mask_pkg::SEL_W-1:0] sel,
		input logic [exc_mask_pkg::SEL_W-1:0] which
	);
		return ok && (sel == which);
	endfunction : write_hits

	assign handler_now    = (mode == exc_mask_pkg::MODE_HANDLER);
	// Only privileged code may write; handler mode may write whatever thread_privileged_in says
	assign wr_ok          = special_req.write & (handler_now | thread_privileged_in);
	assign entry          = exc_req.take & allowed;
	// A return strobe outside handler mode has nothing to unwind
	assign exit_now       = handler_exit & handler_now;
	assign pri_mask_hit   = write_hits(wr_ok, special_req.sel, exc_mask_pkg::SEL_PRI_MASK);
	assign fault_mask_hit = write_hits(wr_ok, special_req.sel, exc_mask_pkg::SEL_FAULT_MASK);
	assign thresh_hit     = write_hits(wr_ok, special_req.sel, exc_mask_pkg::SEL_THRESHOLD);
	assign ctrl_hit       = write_hits(wr_ok, special_req.sel, exc_mask_pkg::SEL_CONTROL);

	prio_gate #(
		.PRIO_W      (PRIO_W)
	) u_gate (
		.pri_mask    (configurable_priority_mask),
		.fault_mask  (fault_level_mask),
		.threshold   (priority_threshold),
		.is_nmi      (exc_req.is_nmi),
		.configurable(exc_req.configurable),
		.prio        (exc_req.prio),
		.allowed     (allowed)
	);

	special_read_mux u_mux (
		.sel         (special_req.sel),
		.pri_mask    (configurable_priority_mask),
		.fault_mask  (fault_level_mask),
		.threshold   (priority_threshold),
		.ctrl_float  (float_context_active),
		.ctrl_stack  (stack_select),
		.ctrl_unpriv (unpriv_bit),
		.in_handler  (handler_now),
		.rdata       (mux_data)
	);

	//////////////////////////////////////////////////////////////////////////////////////////
	// Processor mode
	always_comb begin
		next_mode = mode;
		unique case (mode)
			exc_mask_pkg::MODE_RESET: begin
				next_mode = exc_mask_pkg::MODE_THREAD;
			end
			exc_mask_pkg::MODE_THREAD: begin
				if (entry) next_mode = exc_mask_pkg::MODE_HANDLER;
			end
			exc_mask_pkg::MODE_HANDLER: begin
				if (handler_exit && !entry && return_code[exc_mask_pkg::RET_THREAD_BIT])
					next_mode = exc_mask_pkg::MODE_THREAD;
			end
			default: begin
				next_mode = exc_mask_pkg::MODE_THREAD;
			end
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			mode <= exc_mask_pkg::MODE_RESET;
		end else begin
			mode <= next_mode;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// Configurable priority mask
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			configurable_priority_mask <= exc_mask_pkg::MASK_RESET;
		end else if (change_state.valid && change_state.affect_pri) begin
			configurable_priority_mask <= change_state.set;
		end else if (pri_mask_hit) begin
			configurable_priority_mask <= special_req.wdata[exc_mask_pkg::MASK_BIT];
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// Fault level mask; clearing on handler exit loses to a same-cycle set
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			fault_level_mask <= exc_mask_pkg::MASK_RESET;
		end else if (change_state.valid && change_state.affect_fault) begin
			fault_level_mask <= change_state.set;
		end else if (fault_mask_hit) begin
			fault_level_mask <= special_req.wdata[exc_mask_pkg::MASK_BIT];
		end else if (exit_now && !return_from_nmi) begin
			fault_level_mask <= exc_mask_pkg::MASK_RESET;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// Priority threshold, low nibble reserved
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			priority_threshold <= exc_mask_pkg::THRESH_RESET;
		end else if (thresh_hit) begin
			priority_threshold <=
				special_req.wdata[exc_mask_pkg::THRESH_MSB:exc_mask_pkg::THRESH_LSB];
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// Control register
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			float_context_active <= exc_mask_pkg::CTRL_BIT_RESET;
		end else if (fp_instr_exec) begin
			float_context_active <= 1'b1;
		end else if (entry) begin
			float_context_active <= exc_mask_pkg::CTRL_BIT_RESET;
		end else if (exit_now) begin
			float_context_active <= ~return_code[exc_mask_pkg::RET_FP_BIT];
		end else if (ctrl_hit) begin
			float_context_active <= special_req.wdata[exc_mask_pkg::CTRL_FLOAT_BIT];
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			stack_select <= exc_mask_pkg::CTRL_BIT_RESET;
		end else if (entry) begin
			stack_select <= exc_mask_pkg::CTRL_BIT_RESET;
		end else if (exit_now) begin
			stack_select <= return_code[exc_mask_pkg::RET_THREAD_BIT]
				& return_code[exc_mask_pkg::RET_STACK_BIT];
		end else if (ctrl_hit && !handler_now) begin
			stack_select <= special_req.wdata[exc_mask_pkg::CTRL_STACK_BIT];
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			unpriv_bit <= exc_mask_pkg::CTRL_BIT_RESET;
		end else if (ctrl_hit) begin
			unpriv_bit <= special_req.wdata[exc_mask_pkg::CTRL_UNPRIV_BIT];
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// Registered outputs
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			read_data  <= exc_mask_pkg::ZERO_WORD;
			read_valid <= 1'b0;
		end else begin
			read_valid <= special_req.read;
			read_data  <= special_req.read ? mux_data : exc_mask_pkg::ZERO_WORD;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			exc_accept  <= 1'b0;
			exc_save_fp <= 1'b0;
		end else begin
			exc_accept  <= entry;
			exc_save_fp <= entry & float_context_active;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			in_handler          <= 1'b0;
			use_process_stack   <= 1'b0;
			thread_unprivileged <= 1'b0;
		end else begin
			in_handler          <= handler_now;
			use_process_stack   <= stack_select & ~handler_now;
			thread_unprivileged <= unpriv_bit & ~handler_now;
		end
	end

	// Registered copies of the three masks
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pri_mask_out   <= exc_mask_pkg::MASK_RESET;
			fault_mask_out <= exc_mask_pkg::MASK_RESET;
			threshold_out  <= exc_mask_pkg::THRESH_RESET;
		end else begin
			pri_mask_out   <= configurable_priority_mask;
			fault_mask_out <= fault_level_mask;
			threshold_out  <= priority_threshold;
		end
	end
endmodule : exception_mask_and_stack_control

// ==== sim/exc_mask_assertions.sv ====
// Concurrent checks on the ports of the exception mask and stack control block
module exc_mask_assertions #(
	parameter int PRIO_W = 4
) (
	input wire logic                        clock,
	input wire logic                        nrst,
	input wire exc_mask_pkg::special_req_t  special_req,
	input wire exc_mask_pkg::change_state_t change_state,
	input wire exc_mask_pkg::exc_req_t      exc_req,
	input wire logic                        handler_exit,
	input wire logic                        return_from_nmi,
	input wire logic [7:0]                  return_code,
	input wire logic [31:0]                 read_data,
	input wire logic                        read_valid,
	input wire logic                        exc_accept,
	input wire logic                        in_handler,
	input wire logic                        use_process_stack,
	input wire logic                        pri_mask_out,
	input wire logic                        fault_mask_out,
	input wire logic [3:0]                  threshold_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking dc @(posedge clock); endclocking
	default disable iff (!nrst);

	////////////////////////////////////////////////////////////////////////////////
	// Mask outputs lag the gate by one cycle, so they are read one cycle after take
	a_pri_blocks: assert property (
		exc_req.take && exc_req.configurable && !exc_req.is_nmi ##1 pri_mask_out
		|-> !exc_accept) else $error("masked configurable exception accepted");
	a_fault_blocks: assert property (
		exc_req.take && !exc_req.is_nmi ##1 fault_mask_out |-> !exc_accept)
		else $error("exception accepted under fault mask");
	a_nmi_passes: assert property (
		exc_req.take && exc_req.is_nmi |=> exc_accept) else $error("nmi not accepted");
	a_thresh_blocks: assert property (
		exc_req.take && exc_req.configurable ##1
		threshold_out != 4'h0 && $past(exc_req.prio) >= threshold_out |-> !exc_accept)
		else $error("exception at or below threshold accepted");
	a_open_accepts: assert property (
		exc_req.take ##1 !pri_mask_out && !fault_mask_out && threshold_out == 4'h0
		|-> exc_accept) else $error("unmasked exception refused");
	a_handler_entry: assert property (
		exc_accept |=> in_handler) else $error("handler mode not entered");
	a_handler_main: assert property (
		in_handler |-> !use_process_stack) else $error("process stack used in handler");
	a_fault_clear: assert property (
		handler_exit && !return_from_nmi && !change_state.valid && !special_req.write
		|=> ##1 !fault_mask_out) else $error("fault mask kept after handler exit");
	a_return_process: assert property (
		handler_exit && return_code[3:2] == 2'h3 && !exc_req.take ##1 !exc_req.take
		|=> use_process_stack) else $error("return code did not select process stack");
	a_read_reserved: assert property (
		special_req.read |=> read_valid && read_data[31:8] == 24'h0)
		else $error("read answer missing or reserved bits set");
endmodule : exc_mask_assertions

bind exception_mask_and_stack_control exc_mask_assertions #(.PRIO_W(PRIO_W)) chk (
	.clock(clock), .nrst(nrst), .special_req(special_req), .change_state(change_state),
	.exc_req(exc_req), .handler_exit(handler_exit), .return_from_nmi(return_from_nmi),
	.return_code(return_code), .read_data(read_data), .read_valid(read_valid),
	.exc_accept(exc_accept), .in_handler(in_handler), .use_process_stack(use_process_stack),
	.pri_mask_out(pri_mask_out), .fault_mask_out(fault_mask_out),
	.threshold_out(threshold_out));

// ==== sim/exception_mask_and_stack_control_tb.sv ====
// Self-checking bench for the exception mask and stack control block
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module exception_mask_and_stack_control_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic                        clock;
	logic                        nrst;
	exc_mask_pkg::special_req_t  special_req;
	exc_mask_pkg::change_state_t change_state;
	exc_mask_pkg::exc_req_t      exc_req;
	logic                        handler_exit;
	logic                        return_from_nmi;
	logic [7:0]                  return_code;
	logic                        fp_instr_exec;
	logic                        thread_privileged_in;
	logic [31:0]                 read_data;
	logic                        read_valid;
	logic                        exc_accept;
	logic                        exc_save_fp;
	logic                        in_handler;
	logic                        use_process_stack;
	logic                        thread_unprivileged;
	logic                        pri_mask_out;
	logic                        fault_mask_out;
	logic [3:0]                  threshold_out;
	int                          miscompares;
	int                          checks_done;

	exception_mask_and_stack_control dut (
		.clock(clock), .nrst(nrst), .special_req(special_req), .change_state(change_state),
		.exc_req(exc_req), .handler_exit(handler_exit), .return_from_nmi(return_from_nmi),
		.return_code(return_code), .fp_instr_exec(fp_instr_exec),
		.thread_privileged_in(thread_privileged_in), .read_data(read_data),
		.read_valid(read_valid), .exc_accept(exc_accept), .exc_save_fp(exc_save_fp),
		.in_handler(in_handler), .use_process_stack(use_process_stack),
		.thread_unprivileged(thread_unprivileged), .pri_mask_out(pri_mask_out),
		.fault_mask_out(fault_mask_out), .threshold_out(threshold_out));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Each access pulses for one cycle and then idles one, so outputs have settled
	task automatic wr(input logic [1:0] sel, input logic [31:0] d);
		special_req = '{write: 1'b1, read: 1'b0, sel: sel, wdata: d};
		@(negedge clock);
		special_req = '0;
		@(negedge clock);
	endtask : wr

	task automatic rd(input logic [1:0] sel, input logic [31:0] exp);
		special_req = '{write: 1'b0, read: 1'b1, sel: sel, wdata: 32'h0};
		@(negedge clock);
		`CHK({read_valid, read_data}, {1'b1, exp})
		special_req = '0;
		@(negedge clock);
	endtask : rd

	// Expected pair is accept then floating-point save
	task automatic ex(input logic nmi, input logic cfg, input logic [3:0] p,
			input logic [1:0] exp);
		exc_req = '{take: 1'b1, is_nmi: nmi, configurable: cfg, prio: p};
		@(negedge clock);
		`CHK({exc_accept, exc_save_fp}, exp)
		exc_req = '0;
		@(negedge clock);
	endtask : ex

	task automatic ret(input logic [7:0] code, input logic nmi);
		handler_exit = 1'b1;
		return_code = code;
		return_from_nmi = nmi;
		@(negedge clock);
		handler_exit = 1'b0;
		return_from_nmi = 1'b0;
		@(negedge clock);
	endtask : ret

	task automatic cs(input logic s, input logic p, input logic f);
		change_state = '{valid: 1'b1, set: s, affect_pri: p, affect_fault: f};
		@(negedge clock);
		change_state = '0;
		@(negedge clock);
	endtask : cs

	task automatic final_report();
		$display("Checks done %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report

	// The sequence needs about 130 cycles
	initial begin
		repeat (3000) @(posedge clock);
		miscompares++;
		final_report();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		nrst = 1'b0;
		special_req = '0;
		change_state = '0;
		exc_req = '0;
		handler_exit = 1'b0;
		return_from_nmi = 1'b0;
		return_code = 8'h00;
		fp_instr_exec = 1'b0;
		thread_privileged_in = 1'b1;
		miscompares = 0;
		checks_done = 0;
		repeat (2) @(negedge clock);
		nrst = 1'b1;
		repeat (2) @(negedge clock);
		for (int i = 0; i < 4; i++) rd(i[1:0], 32'h0);
		`CHK({in_handler, use_process_stack, thread_unprivileged}, 3'h0)
		$display("reset test done");
		wr(2'h0, 32'hffff_ffff);
		rd(2'h0, 32'h1);
		`CHK(pri_mask_out, 1'b1)
		ex(1'b0, 1'b1, 4'h1, 2'h0);
		ex(1'b0, 1'b0, 4'h1, 2'h2);
		ret(8'h19, 1'b0);
		cs(1'b0, 1'b1, 1'b0);
		ex(1'b0, 1'b1, 4'h1, 2'h2);
		ret(8'h19, 1'b0);
		$display("priority mask test done");
		cs(1'b1, 1'b0, 1'b1);
		`CHK({pri_mask_out, fault_mask_out}, 2'h1)
		ex(1'b0, 1'b0, 4'h0, 2'h0);
		ex(1'b1, 1'b0, 4'h0, 2'h2);
		ret(8'h19, 1'b1);
		rd(2'h1, 32'h1);
		cs(1'b0, 1'b0, 1'b1);
		ex(1'b0, 1'b1, 4'h2, 2'h2);
		cs(1'b1, 1'b0, 1'b1);
		ret(8'h19, 1'b0);
		rd(2'h1, 32'h0);
		`CHK(fault_mask_out, 1'b0)
		$display("fault mask test done");
		wr(2'h2, 32'hffff_ff5f);
		rd(2'h2, 32'h50);
		`CHK(threshold_out, 4'h5)
		for (int p = 0; p < 16; p++) begin
			ex(1'b0, 1'b1, p[3:0], {p < 5, 1'b0});
			if (p < 5) ret(8'h19, 1'b0);
		end
		wr(2'h2, 32'h0);
		ex(1'b0, 1'b1, 4'hf, 2'h2);
		ret(8'h19, 1'b0);
		$display("threshold test done");
		fp_instr_exec = 1'b1;
		@(negedge clock);
		fp_instr_exec = 1'b0;
		@(negedge clock);
		rd(2'h3, 32'h4);
		wr(2'h3, 32'hffff_ffff);
		rd(2'h3, 32'h7);
		`CHK({use_process_stack, thread_unprivileged}, 2'h3)
		ex(1'b0, 1'b0, 4'h0, 2'h3);
		`CHK({in_handler, use_process_stack, thread_unprivileged}, 3'h4)
		rd(2'h3, 32'h1);
		wr(2'h3, 32'h2);
		rd(2'h3, 32'h0);
		ret(8'h1d, 1'b0);
		`CHK({in_handler, use_process_stack, thread_unprivileged}, 3'h2)
		rd(2'h3, 32'h2);
		thread_privileged_in = 1'b0;
		wr(2'h3, 32'h0);
		wr(2'h0, 32'h1);
		rd(2'h3, 32'h2);
		rd(2'h0, 32'h0);
		thread_privileged_in = 1'b1;
		wr(2'h3, 32'h0);
		rd(2'h3, 32'h0);
		`CHK(use_process_stack, 1'b0)
		$display("control test done");
		final_report();
	end
endmodule : exception_mask_and_stack_control_tb
